/* File: sac_ctrl.sv */
`timescale 1ns/1ns
`include "sac_map.svh"
module sac_ctrl
	import sac_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        ce,
	input  wire logic        reset_in,
	input  wire logic        conv_start_n,
	input  wire logic        power_down_in,
	input  wire logic        ref_power_down,
	input  wire logic        refbuf_power_down,
	input  wire logic [17:0] sar_code,
	input  wire logic        sclk_in,
	input  wire sac_rd_t     rd,
	output sac_bus_t         bus,
	output logic             busy,
	output logic             hold,
	output logic             ref_enable,
	output logic             refbuf_enable,
	output logic             sclk_gated,
	output logic             powered_down
);
	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	logic       rst_s1;
	logic       rst_n;

	// two-stage release of the asynchronous reset
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rst_s1 <= 1'b0;
			rst_n  <= 1'b0;
		end
		else
		begin
			rst_s1 <= 1'b1;
			rst_n  <= rst_s1;
		end
	end

	// ------------------------------------------------------------
	// edges and counter
	// ------------------------------------------------------------
	logic       start_fall;
	logic       reset_fall;
	logic       cnt_done;
	logic       cnt_load;
	logic [7:0] cnt_val;
	sac_state_t state;
	sac_state_t next_state;
	logic [17:0] result;
	logic        pd_latched;

	// conversion start edge
	sac_edge u_start_edge
	(
		.clk   (clk),
		.rst_n (rst_n),
		.ce    (ce),
		.level (conv_start_n),
		.fall  (start_fall)
	);

	// reset pin falling edge; pin idles low, so no calibration right after reset
	sac_edge
	#(
		.IDLE (1'b0)
	)
	u_reset_edge
	(
		.clk   (clk),
		.rst_n (rst_n),
		.ce    (ce),
		.level (reset_in),
		.fall  (reset_fall)
	);

	// conversion and calibration timer
	sac_count u_timer
	(
		.clk      (clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.load     (cnt_load),
		.load_val (cnt_val),
		.run      (state != SAC_IDLE),
		.done     (cnt_done)
	);

	// ------------------------------------------------------------
	// conversion sequencer
	// ------------------------------------------------------------
	logic start_ok;

	// starts refused in power-down or while reset is high
	assign start_ok = start_fall & ~pd_latched & ~reset_in;

	// next state and counter load
	always_comb
	begin
		next_state = state;
		cnt_load   = 1'b0;
		cnt_val    = 8'h00;
		case (state)
			SAC_IDLE:
			begin
				if (reset_fall)
				begin
					next_state = SAC_CAL;
					cnt_load   = 1'b1;
					cnt_val    = 8'(`SAC_CAL_CYC);
				end
				else if (start_ok)
				begin
					next_state = SAC_CONV;
					cnt_load   = 1'b1;
					cnt_val    = 8'(`SAC_CONV_CYC);
				end
			end
			SAC_CONV:
			begin
				if (cnt_done)
					next_state = SAC_IDLE;
			end
			SAC_CAL:
			begin
				if (cnt_done)
					next_state = SAC_IDLE;
			end
			default:
				next_state = SAC_IDLE;
		endcase
		if (reset_in)
		begin
			next_state = SAC_IDLE; // abandon any conversion
			cnt_load   = 1'b0;
		end
	end

	// state register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			state <= SAC_IDLE;
		else if (ce)
			state <= next_state;
	end

	// busy high through conversion and calibration
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			busy <= 1'b0;
		else if (ce)
			busy <= (next_state != SAC_IDLE);
	end

	// sampler held during conversion
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			hold <= 1'b0;
		else if (ce)
			hold <= (next_state == SAC_CONV);
	end

	// result latched at the end, then left alone
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			result <= 18'h0_0000;
		else if (ce && state == SAC_CONV && cnt_done && !reset_in)
			result <= sar_code;
	end

	// power-down takes effect only when no conversion runs
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pd_latched <= 1'b0;
		else if (ce && (state == SAC_IDLE || !power_down_in))
			pd_latched <= power_down_in;
	end

	assign powered_down = pd_latched;

	// reference enables
	assign ref_enable    = ~ref_power_down;
	assign refbuf_enable = ~refbuf_power_down;

	// ------------------------------------------------------------
	// output bus
	// ------------------------------------------------------------
	logic [17:0] coded;
	logic        read_en;
	logic [17:0] next_data;
	logic [17:0] next_oe;

	// two's complement when format select is low
	assign coded   = rd.format_select ? result : (result ^ 18'h2_0000);
	assign read_en = ~rd.cs_n & ~rd.rd_n;

	// serial clock gated by chip select
	assign sclk_gated = sclk_in & ~rd.cs_n & (rd.iface_sel == `SAC_MODE_SERIAL);

	// lane steering per interface mode
	always_comb
	begin
		next_data = 18'h0_0000;
		next_oe   = 18'h0_0000;
		case (rd.iface_sel)
			`SAC_MODE_PAR18:
			begin
				next_data = coded;
				next_oe   = 18'h3_FFFF;
			end
			`SAC_MODE_PAR16:
			begin
				next_oe = 18'h3_FFFC; // lines 0,1 are inputs
				if (!rd.word_addr)
					next_data = {coded[17:2], 2'b00};
				else
					next_data = {14'h0000, coded[1:0], 2'b00};
			end
			`SAC_MODE_PAR8:
			begin
				next_oe = 18'h3_FC00; // lines 0-9 float
				case ({rd.word_addr, rd.byte_addr_hi})
					2'b00:   next_data = {coded[17:10], 10'h000};
					2'b01:   next_data = {coded[9:2], 10'h000};
					2'b10:   next_data = {6'h00, coded[1:0], 10'h000};
					2'b11:   next_data = {coded[1:0], 16'h0000};
					default: next_data = 18'h0_0000;
				endcase
			end
			`SAC_MODE_SERIAL:
			begin
				next_oe = 18'h3_C000; // low lines float, upper driven
				next_data = {coded[17:14], 14'h0000};
			end
			default:
			begin
				next_data = 18'h0_0000;
				next_oe   = 18'h0_0000;
			end
		endcase
		if (!read_en)
			next_oe = 18'h3_C000 & next_oe;
		next_oe[17:`SAC_TOP_LO] = 4'hF;
	end

	// registered bus outputs
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			bus <= '{data: 18'h0_0000, oe: 18'h3_C000};
		else if (ce)
			bus <= '{data: next_data, oe: next_oe};
	end
endmodule

/* File: sac_map.svh */
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH
// result and bus geometry
`define SAC_RES_W        18
`define SAC_BUS_W        18
// interface mode codes {hi,lo}
`define SAC_MODE_PAR18   2'h0
`define SAC_MODE_PAR16   2'h1
`define SAC_MODE_PAR8    2'h2
`define SAC_MODE_SERIAL  2'h3
// always-driven upper lines
`define SAC_TOP_LO       14
// timing, figures in ns at a 50 ns clock
`define SAC_CLK_NS       50
`define SAC_CONV_NS      500
`define SAC_CONV_CYC     ((`SAC_CONV_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)
`define SAC_CAL_NS       1000
`define SAC_CAL_CYC      ((`SAC_CAL_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)
`define SAC_CNT_W        8
// two's complement flips the msb
`define SAC_MSB          17
`endif

/* File: sac_pkg.sv */
package sac_pkg;
	typedef enum logic [1:0] {
		SAC_IDLE,
		SAC_CONV,
		SAC_CAL
	} sac_state_t;

	typedef struct packed {
		logic       cs_n;
		logic       rd_n;
		logic       format_select;
		logic       word_addr;
		logic       byte_addr_hi;
		logic [1:0] iface_sel;
	} sac_rd_t;

	typedef struct packed {
		logic [17:0] data;
		logic [17:0] oe;
	} sac_bus_t;
endpackage

/* File: sac_edge.sv */
`timescale 1ns/1ns
// one-cycle falling edge detector on a synchronous level
module sac_edge
#(
	parameter logic IDLE = 1'b1 // idle level of the watched pin
)
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	input  wire logic level,
	output logic      fall
);
	logic prev;

	// hold last level; reset to the idle level so no false edge
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			prev <= IDLE;
		else if (ce)
			prev <= level;
	end

	assign fall = ce & prev & ~level;
endmodule

/* File: sac_count.sv */
`timescale 1ns/1ns
// down counter: load then count to zero, done pulses on last step
module sac_count
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	input  wire logic       load,
	input  wire logic [7:0] load_val,
	input  wire logic       run,
	output logic            done
);
	logic [7:0] cnt;

	// countdown while run
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt <= 8'h00;
		else if (ce)
		begin
			if (load)
				cnt <= load_val;
			else if (run && cnt != 8'h00)
				cnt <= cnt - 8'h01;
		end
	end

	assign done = ce & run & ~load & (cnt == 8'h01);
endmodule

/* File: sac_host.sv */
`timescale 1ns/1ns
// host model: strobes conversion starts and waits for data ready
module sac_host
(
	input  wire logic clk,
	input  wire logic busy,
	input  wire logic ext,
	output logic      conv_start_n,
	output logic      ref_power_down,
	output logic      refbuf_power_down
);
	// buffer stays on whenever the internal reference is used
	assign ref_power_down = ext;
	assign refbuf_power_down = ext;
	initial conv_start_n = 1'b1;
	// one-cycle strobe, only once busy is low
	task automatic start();
		while (busy === 1'b1) @(posedge clk);
		@(posedge clk) conv_start_n <= 1'b0;
		@(posedge clk) conv_start_n <= 1'b1;
	endtask
	// bounded wait for the busy fall that marks data ready; n counts edges waited
	task automatic ready(output bit ok, output int n);
		ok = 1'b0;
		n  = 0;
		while (!ok && n < 40)
		begin
			@(posedge clk);
			#1;
			n++;
			ok = (busy === 1'b0);
		end
	endtask
endmodule

/* File: sac_ctrl_chk.sv */
`timescale 1ns/1ns
// port checker for the conversion control block
module sac_ctrl_chk
	import sac_pkg::*;
(
	input  wire logic     clk,
	input  wire logic     rst_b,
	input  wire logic     ce,
	input  wire logic     reset_in,
	input  wire logic     conv_start_n,
	input  wire logic     power_down_in,
	input  wire sac_rd_t  rd,
	input  wire sac_bus_t bus,
	input  wire logic     busy,
	input  wire logic     hold,
	input  wire logic     sclk_gated,
	input  wire logic     powered_down
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b || !ce);
	top_lines_a: assert property (bus.oe[17:14] == 4'hF)
		else $error("upper lines released");
	conv_len_a: assert property (disable iff (!rst_b || reset_in || !ce) $fell(conv_start_n)
		&& !(busy || powered_down || power_down_in) |=> (busy && hold)[*8] ##1 busy[*2] ##1 !busy)
		else $error("conversion length");
	hold_busy_a: assert property (hold |-> busy)
		else $error("hold outside busy");
	pd_block_a: assert property (powered_down && !busy && !reset_in && !$fell(reset_in) |=> !busy)
		else $error("start in power down");
	reset_idle_a: assert property (reset_in[*2] |=> !busy && !hold)
		else $error("busy in reset");
	cal_pulse_a: assert property ($fell(reset_in) |-> ##[1:2] busy)
		else $error("no calibration pulse");
	bus_off_a: assert property (rd.cs_n || rd.rd_n |=> bus.oe[13:0] == 14'h0)
		else $error("bus driven unread");
	serial_float_a: assert property (rd.iface_sel == 2'h3 |=> bus.oe[9:0] == 10'h000)
		else $error("low lines driven");
	sclk_gate_a: assert property (rd.cs_n |-> !sclk_gated)
		else $error("clock not gated");
endmodule
bind sac_ctrl sac_ctrl_chk i_chk (.*);

/* File: sac_ctrl_tb.sv */
`timescale 1ns/1ns
`include "sac_map.svh"
module sac_ctrl_tb
	import sac_pkg::*;
;
	typedef struct packed {
		logic [5:0]  s;
		logic [17:0] oe;
		logic [17:0] d;
	} sac_row_t;
	// read setup {cs_n,mode,word,byte,format} beside expected drive and data
	localparam sac_row_t ROWS [10] = '{
		'{6'h01, 18'h3_FFFF, 18'h2_D5A3},
		'{6'h00, 18'h3_FFFF, 18'h0_D5A3},
		'{6'h09, 18'h3_FFFC, 18'h2_D5A0},
		'{6'h08, 18'h3_FFFC, 18'h0_D5A0},
		'{6'h0D, 18'h3_FFFC, 18'h0_000C},
		'{6'h11, 18'h3_FC00, 18'h2_D400},
		'{6'h13, 18'h3_FC00, 18'h1_A000},
		'{6'h15, 18'h3_FC00, 18'h0_0C00},
		'{6'h17, 18'h3_FC00, 18'h3_0000},
		'{6'h21, 18'h3_C000, 18'h2_C000}
	};
	logic        clk;
	logic        rst_b = 1'b0;
	logic        reset_in = 1'b0;
	logic        power_down_in = 1'b0;
	logic        ce = 1'b1;
	logic        sclk_in = 1'b0;
	logic        ext = 1'b0;
	logic [17:0] sar_code = 18'h0_0000;
	sac_rd_t     rd = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 2'h0};
	sac_bus_t    bus;
	logic        busy, hold, ref_enable, refbuf_enable, sclk_gated, powered_down;
	logic        conv_start_n, ref_power_down, refbuf_power_down;
	int          n_mismatch = 0;
	int          total_checks = 0;
	int          cycles = 0;
	int          n_cyc;
	bit          ok;
	sac_ctrl i_dut (.*);
	sac_host i_host (.*);
	// 50 ns clock
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// cycle ceiling against hangs
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 2000)
		begin
			n_mismatch++;
			summarize();
		end
	end
	task automatic summarize();
		if (n_mismatch == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check(string nm, logic [17:0] got, logic [17:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// set up a read, then sample once the registered bus has settled
	task automatic read_bus(logic [5:0] s);
		@(posedge clk) rd <= '{s[5], 1'b0, s[0], s[2], s[1], s[4:3]};
		@(posedge clk);
		#1;
	endtask
	task automatic convert(logic [17:0] code);
		@(posedge clk) sar_code <= code;
		i_host.start();
		#1;
		check("busy hold", 18'({busy, hold}), 18'h0_0003);
		i_host.ready(ok, n_cyc);
		check("conv len", 18'(n_cyc), 18'(`SAC_CONV_CYC));
		check("ready", 18'(ok), 18'h0_0001);
	endtask
	// main sequence: table first, then the awkward cases
	initial
	begin
		repeat (10) @(posedge clk);
		check("init oe", bus.oe, 18'h3_C000);
		check("init busy", 18'({busy, hold}), 18'h0_0000);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		convert(18'h2_D5A3);
		foreach (ROWS[i])
		begin
			read_bus(ROWS[i].s);
			check("oe", bus.oe, ROWS[i].oe);
			check("data", bus.data & bus.oe, ROWS[i].d);
		end
		read_bus(6'h19);
		check("serial", bus.oe & 18'h3_C3FF, 18'h3_C000);
		// a new core code alone leaves the latch as it was
		@(posedge clk) sar_code <= 18'h1_2345;
		read_bus(6'h01);
		check("held", bus.data, 18'h2_D5A3);
		// power down mid conversion: finish it, then refuse
		@(posedge clk) sar_code <= 18'h0_0F0F;
		i_host.start();
		@(posedge clk) power_down_in <= 1'b1;
		i_host.ready(ok, n_cyc);
		read_bus(6'h01);
		check("pd last", bus.data, 18'h0_0F0F);
		i_host.start();
		repeat (3) @(posedge clk);
		#1;
		check("pd busy", {busy, 16'h0000, powered_down}, 18'h0_0001);
		// reset high refuses starts, its fall runs calibration
		@(posedge clk) power_down_in <= 1'b0;
		@(posedge clk) reset_in <= 1'b1;
		i_host.start();
		#1;
		check("rst busy", 18'(busy), 18'h0_0000);
		@(posedge clk) reset_in <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		check("cal busy", 18'(busy), 18'h0_0001);
		i_host.ready(ok, n_cyc);
		check("cal len", 18'(n_cyc), 18'(`SAC_CAL_CYC - 1));
		convert(18'h1_2345);
		read_bus(6'h01);
		check("new", bus.data, 18'h1_2345);
		// a start strobe while the clock enable is low is never seen
		@(posedge clk) ce <= 1'b0;
		i_host.start();
		@(posedge clk) ce <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		check("ce freeze", 18'(busy), 18'h0_0000);
		// serial clock passes only with chip select low
		read_bus(6'h19);
		for (int c = 0; c < 4; c++)
		begin
			@(posedge clk) sclk_in <= c[0];
			rd.cs_n <= c[1];
			#1;
			check("sclk", 18'(sclk_gated), 18'(c == 1));
		end
		for (int e = 0; e < 2; e++)
		begin
			@(posedge clk) ext <= e[0];
			@(posedge clk);
			check("ref", {16'h0000, ref_enable, refbuf_enable}, {16'h0000, !e[0], !e[0]});
		end
		summarize();
	end
endmodule
